/* csr_params.svh */
// Address map, reset values and field positions of the core system registers.
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
`define CSR_OFF_SP      8'h81
`define CSR_OFF_DPL     8'h82
`define CSR_OFF_DPH     8'h83
`define CSR_OFF_PSW     8'hD0
`define CSR_OFF_ACC     8'hE0
`define CSR_OFF_B       8'hF0
`define CSR_OFF_RSTCTL  8'hC0
`define CSR_OFF_TA      8'hC1
`define CSR_RST_SP      8'h07
`define CSR_RST_ZERO    8'h00
`define CSR_ADDR_LSB    2
`define CSR_ADDR_MSB    9
`define CSR_ADDR_TOP    31
`define CSR_ADDR_HIGH   10
`define CSR_BIT_CY      7
`define CSR_BIT_AC      6
`define CSR_BIT_F0      5
`define CSR_BIT_RS1     4
`define CSR_BIT_RS0     3
`define CSR_BIT_OV      2
`define CSR_BIT_F1      1
`define CSR_BIT_P       0
`define CSR_TA_KEY1     8'hAA
`define CSR_TA_KEY2     8'h55
`define CSR_TA_WIN      3'h4
`define CSR_BCD_LIMIT   9'h064
`define CSR_MUL_LIMIT   16'h00FF
`define CSR_RSTK_SOFT   2'h1
`endif

/* csr_pkg.sv */
// Types shared by the core system register block.
package csr_pkg;
  typedef enum logic [3:0] {
    CSR_OP_NONE, CSR_OP_ADD, CSR_OP_ADDC, CSR_OP_SUBB, CSR_OP_MUL,
    CSR_OP_DIV, CSR_OP_DA, CSR_OP_COMPARE_BRANCH_INSTR, CSR_OP_PUSH, CSR_OP_POP
  } csr_op_t;
  typedef struct packed {
    csr_op_t    op;
    logic [7:0] operand;
  } csr_core_req_t;
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] sp;
    logic [15:0] wide_data_pointer;
    logic [7:0] status_word;
    logic [1:0] bank;
    logic [4:0] bank_base;
    logic [7:0] stack_wr_addr;
    logic       stack_wr_en;
  } csr_core_view_t;
endpackage

/* csr_core_regs.sv */
// Core system registers with an APB slave and a small arithmetic flag unit.
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"
// Overview of operation
// - Main operand register, 8 bits, read/write, resets to zero.
// - Second operand register, resets to zero, holds multiply/divide operand and result.
// - Push increments the stack pointer first, then writes at the new address.
// - Stack pointer resets to 07H so the first push lands at 08H.
// - High and low pointer bytes form one 16-bit data pointer.
// - Add and subtract set carry on carry out of or borrow into bit 7.
// - Multiply and divide always clear the carry flag.
// - Compare-and-branch sets carry when first unsigned operand is below second.
// - Decimal adjust sets carry when the packed BCD sum exceeded 99.
// - Nibble carry flag follows carry or borrow at bit 3 into bit 4.
// - Status bit 5 is a free user flag with no hardware effect.
// - Bank select bits choose working register base 00, 08, 10 or 18H.
// - Status word resets to zero with the documented bit layout.
// - Protected registers accept writes only inside an open timed-access window.
// - Bits marked unchanged keep their contents across a soft reset.
// - Reset-control register loads the configuration byte whenever the load input is high.
// - Overflow flag: add bit 6/7 carry mismatch, product above 255, divide by 0.
// - Parity flag is set for an odd number of ones in the main operand.
module csr_core_regs (
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [31:0]            paddr_in,
  input  wire logic [31:0]            pwdata_in,
  input  wire logic [3:0]             pstrb_in,
  output logic      [31:0]            prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  input  wire csr_pkg::csr_core_req_t core_req_in,
  input  wire logic [7:0]             cfg_byte_in,
  input  wire logic                   cfg_load_in,
  output csr_pkg::csr_core_view_t     view_out
);
  logic [7:0]  acc_r, b_r, sp_r, dpl_r, dph_r, psw_r;
  logic [7:0]  rstctl_r;
  logic [2:0]  ta_cnt_r;
  logic        ta_armed_r;
  logic        ta_open;
  logic        wr_en, rd_en, strb_ok, hit;
  logic [7:0]  sel_addr, wbyte, rd_byte;
  logic [8:0]  add_sum, sub_diff;
  logic [4:0]  nib_add, nib_sub;
  logic [7:0]  low7_add, low7_sub;
  logic [15:0] prod;
  logic [8:0]  da_sum;
  logic        cin;
  logic [7:0]  acc_nxt, b_nxt, psw_nxt, sp_nxt;

  // Reports whether a byte address maps to a register index; high bits must be zero.
  function automatic logic csr_hit(input logic [31:0] a);
    logic [7:0] i;
    i = a[`CSR_ADDR_MSB:`CSR_ADDR_LSB];
    csr_hit = (a[`CSR_ADDR_TOP:`CSR_ADDR_HIGH] == '0) &&
              (a[1:0] == 2'h0) &&
              (i == `CSR_OFF_SP || i == `CSR_OFF_DPL ||
               i == `CSR_OFF_DPH || i == `CSR_OFF_PSW ||
               i == `CSR_OFF_ACC || i == `CSR_OFF_B ||
               i == `CSR_OFF_RSTCTL || i == `CSR_OFF_TA);
  endfunction

  // Odd parity of a byte.
  function automatic logic csr_odd(input logic [7:0] v);
    csr_odd = ^v;
  endfunction

  // APB decode: zero wait states, unmapped addresses answer with an error.
  assign sel_addr   = paddr_in[`CSR_ADDR_MSB:`CSR_ADDR_LSB];
  assign hit        = csr_hit(paddr_in);
  assign strb_ok    = pstrb_in[0];
  assign wr_en      = psel_in && penable_in && pwrite_in && hit && strb_ok;
  assign rd_en      = psel_in && penable_in && !pwrite_in && hit;
  assign wbyte      = pwdata_in[7:0];
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !hit;
  assign ta_open    = ta_cnt_r != 3'h0;

  // Arithmetic helpers for flag generation.
  assign cin      = (core_req_in.op == csr_pkg::CSR_OP_ADD) ? 1'b0
                    : psw_r[`CSR_BIT_CY];
  assign add_sum  = {1'b0, acc_r} + {1'b0, core_req_in.operand} + {8'h00, cin};
  assign sub_diff = {1'b0, acc_r} - {1'b0, core_req_in.operand}
                    - {8'h00, psw_r[`CSR_BIT_CY]};
  assign nib_add  = {1'b0, acc_r[3:0]} + {1'b0, core_req_in.operand[3:0]}
                    + {4'h0, cin};
  assign nib_sub  = {1'b0, acc_r[3:0]} - {1'b0, core_req_in.operand[3:0]}
                    - {4'h0, psw_r[`CSR_BIT_CY]};
  assign low7_add = {1'b0, acc_r[6:0]} + {1'b0, core_req_in.operand[6:0]}
                    + {7'h00, cin};
  assign low7_sub = {1'b0, acc_r[6:0]} - {1'b0, core_req_in.operand[6:0]}
                    - {7'h00, psw_r[`CSR_BIT_CY]};
  assign prod     = acc_r * b_r;

  // Decimal adjust of the main operand register.
  always_comb begin
    da_sum = {1'b0, acc_r};
    if (acc_r[3:0] > 4'h9 || psw_r[`CSR_BIT_AC]) begin
      da_sum = da_sum + 9'h006;
    end
    if (da_sum[8:4] > 5'h09 || psw_r[`CSR_BIT_CY]) begin
      da_sum = da_sum + 9'h060;
    end
  end

  // Next values for the operand registers and the status word.
  always_comb begin
    acc_nxt = acc_r;
    b_nxt   = b_r;
    psw_nxt = psw_r;
    unique case (core_req_in.op)
      csr_pkg::CSR_OP_ADD, csr_pkg::CSR_OP_ADDC: begin
        acc_nxt = add_sum[7:0];
        psw_nxt[`CSR_BIT_CY] = add_sum[8];
        psw_nxt[`CSR_BIT_AC] = nib_add[4];
        psw_nxt[`CSR_BIT_OV] = add_sum[8] ^ low7_add[7];
      end
      csr_pkg::CSR_OP_SUBB: begin
        acc_nxt = sub_diff[7:0];
        psw_nxt[`CSR_BIT_CY] = sub_diff[8];
        psw_nxt[`CSR_BIT_AC] = nib_sub[4];
        psw_nxt[`CSR_BIT_OV] = sub_diff[8] ^ low7_sub[7];
      end
      csr_pkg::CSR_OP_MUL: begin
        acc_nxt = prod[7:0];
        b_nxt   = prod[15:8];
        psw_nxt[`CSR_BIT_CY] = 1'b0;
        psw_nxt[`CSR_BIT_OV] = prod > `CSR_MUL_LIMIT;
      end
      csr_pkg::CSR_OP_DIV: begin
        if (b_r != 8'h00) begin
          acc_nxt = acc_r / b_r;
          b_nxt   = acc_r % b_r;
        end
        psw_nxt[`CSR_BIT_CY] = 1'b0;
        psw_nxt[`CSR_BIT_OV] = b_r == 8'h00;
      end
      csr_pkg::CSR_OP_DA: begin
        acc_nxt = da_sum[7:0];
        psw_nxt[`CSR_BIT_CY] = psw_r[`CSR_BIT_CY] ||
                               ({1'b0, acc_r} + 9'h000 >= `CSR_BCD_LIMIT &&
                                da_sum[8]);
      end
      csr_pkg::CSR_OP_COMPARE_BRANCH_INSTR: begin
        psw_nxt[`CSR_BIT_CY] = acc_r < core_req_in.operand;
      end
      default: begin
      end
    endcase
  end

  // Stack pointer moves: push pre-increments, pop post-decrements.
  always_comb begin
    sp_nxt = sp_r;
    if (core_req_in.op == csr_pkg::CSR_OP_PUSH) begin
      sp_nxt = sp_r + 8'h01;
    end else if (core_req_in.op == csr_pkg::CSR_OP_POP) begin
      sp_nxt = sp_r - 8'h01;
    end
  end

  // Timed-access window: key 1 then key 2 opens a short write window.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ta_armed_r <= 1'b0;
      ta_cnt_r   <= 3'h0;
    end else begin
      if (wr_en && sel_addr == `CSR_OFF_TA) begin
        ta_armed_r <= wbyte == `CSR_TA_KEY1;
        ta_cnt_r   <= (ta_armed_r && wbyte == `CSR_TA_KEY2)
                      ? `CSR_TA_WIN : 3'h0;
      end else if (ta_open) begin
        ta_cnt_r <= ta_cnt_r - 3'h1;
      end
    end
  end

  // Protected reset-control register: writable only while the window is open.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rstctl_r <= `CSR_RST_ZERO;
    end else if (cfg_load_in) begin
      rstctl_r <= cfg_byte_in;
    end else if (wr_en && sel_addr == `CSR_OFF_RSTCTL && ta_open) begin
      rstctl_r <= wbyte;
    end
  end

  // Data pointer: low byte resets, high byte keeps its value over soft reset.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dpl_r <= `CSR_RST_ZERO;
      dph_r <= `CSR_RST_ZERO;
    end else if (rstctl_r[1:0] == `CSR_RSTK_SOFT) begin
      dpl_r <= `CSR_RST_ZERO; // high byte unchanged
    end else if (wr_en && sel_addr == `CSR_OFF_DPL) begin
      dpl_r <= wbyte;
    end else if (wr_en && sel_addr == `CSR_OFF_DPH) begin
      dph_r <= wbyte;
    end
  end

  // Main and second operand registers; the bus write wins over the core.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_r <= `CSR_RST_ZERO;
      b_r   <= `CSR_RST_ZERO;
    end else begin
      acc_r <= (wr_en && sel_addr == `CSR_OFF_ACC) ? wbyte : acc_nxt;
      b_r   <= (wr_en && sel_addr == `CSR_OFF_B) ? wbyte : b_nxt;
    end
  end

  // Stack pointer.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sp_r <= `CSR_RST_SP;
    end else if (wr_en && sel_addr == `CSR_OFF_SP) begin
      sp_r <= wbyte;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // Status word; user flags and bank bits are plain storage.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      psw_r <= `CSR_RST_ZERO;
    end else if (wr_en && sel_addr == `CSR_OFF_PSW) begin
      psw_r <= wbyte;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  // Read mux; parity is always computed live from the main operand.
  always_comb begin
    unique case (sel_addr)
      `CSR_OFF_SP:     rd_byte = sp_r;
      `CSR_OFF_DPL:    rd_byte = dpl_r;
      `CSR_OFF_DPH:    rd_byte = dph_r;
      `CSR_OFF_PSW:    rd_byte = {psw_r[7:1], csr_odd(acc_r)};
      `CSR_OFF_ACC:    rd_byte = acc_r;
      `CSR_OFF_B:      rd_byte = b_r;
      `CSR_OFF_RSTCTL: rd_byte = rstctl_r;
      `CSR_OFF_TA:     rd_byte = {5'h00, ta_cnt_r};
      default:         rd_byte = 8'h00;
    endcase
  end

  // Read data register, loaded in the setup phase.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= 32'h00000000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= {24'h000000, rd_byte};
    end
  end

  // Core-facing view of the register state.
  always_comb begin
    view_out.acc  = acc_r;
    view_out.b    = b_r;
    view_out.sp   = sp_r;
    view_out.wide_data_pointer = {dph_r, dpl_r};
    view_out.status_word  = {psw_r[7:1], csr_odd(acc_r)};
    view_out.bank = {psw_r[`CSR_BIT_RS1], psw_r[`CSR_BIT_RS0]};
    view_out.bank_base = {psw_r[`CSR_BIT_RS1], psw_r[`CSR_BIT_RS0], 3'h0};
    view_out.stack_wr_addr = sp_r + 8'h01;
    view_out.stack_wr_en   = core_req_in.op == csr_pkg::CSR_OP_PUSH;
  end

  property p_sp_reset;
    @(posedge core_clk_in) $fell(rst_in) |-> sp_r == `CSR_RST_SP;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("sp reset wrong");

  property p_push;
    @(posedge core_clk_in) disable iff (rst_in)
      core_req_in.op == csr_pkg::CSR_OP_PUSH && !(wr_en && sel_addr == `CSR_OFF_SP)
      |=> sp_r == $past(sp_r) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push did not increment");

  property p_mul_cy;
    @(posedge core_clk_in) disable iff (rst_in)
      core_req_in.op == csr_pkg::CSR_OP_MUL && !wr_en
      |=> !psw_r[`CSR_BIT_CY] && psw_r[`CSR_BIT_OV] == ($past(prod) > 16'h00FF);
  endproperty
  a_mul_cy: assert property (p_mul_cy) else $error("mul flags wrong");

  property p_div_ov;
    @(posedge core_clk_in) disable iff (rst_in)
      core_req_in.op == csr_pkg::CSR_OP_DIV && !wr_en
      |=> psw_r[`CSR_BIT_OV] == ($past(b_r) == 8'h00);
  endproperty
  a_div_ov: assert property (p_div_ov) else $error("div overflow wrong");

  property p_compare_branch_instr;
    @(posedge core_clk_in) disable iff (rst_in)
      core_req_in.op == csr_pkg::CSR_OP_COMPARE_BRANCH_INSTR && !wr_en
      |=> psw_r[`CSR_BIT_CY] == ($past(acc_r) < $past(core_req_in.operand));
  endproperty
  a_compare_branch_instr: assert property (p_compare_branch_instr) else $error("compare carry wrong");

  property p_add_cy;
    @(posedge core_clk_in) disable iff (rst_in)
      core_req_in.op == csr_pkg::CSR_OP_ADD && !wr_en
      |=> psw_r[`CSR_BIT_CY] == $past(add_sum[8]) &&
          psw_r[`CSR_BIT_AC] == $past(nib_add[4]);
  endproperty
  a_add_cy: assert property (p_add_cy) else $error("add carry wrong");

  property p_parity;
    @(posedge core_clk_in) disable iff (rst_in)
      view_out.status_word[0] == ^acc_r;
  endproperty
  a_parity: assert property (p_parity) else $error("parity wrong");

  property p_ta;
    @(posedge core_clk_in) disable iff (rst_in)
      wr_en && sel_addr == `CSR_OFF_RSTCTL && !ta_open && !cfg_load_in
      |=> rstctl_r == $past(rstctl_r);
  endproperty
  a_ta: assert property (p_ta) else $error("protected write took");

  property p_bank;
    @(posedge core_clk_in) disable iff (rst_in)
      view_out.bank_base == {psw_r[4:3], 3'h0};
  endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");
endmodule // csr_core_regs
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench for the core system register block.
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"
module tb_top;
  logic                   core_clk_in;
  logic                   rst_in;
  logic                   psel_in;
  logic                   penable_in;
  logic                   pwrite_in;
  logic [31:0]            paddr_in;
  logic [31:0]            pwdata_in;
  logic [3:0]             pstrb_in;
  logic [31:0]            prdata_out;
  logic                   pready_out;
  logic                   pslverr_out;
  csr_pkg::csr_core_req_t core_req_in;
  csr_pkg::csr_core_view_t view_out;
  int                     errors;
  int                     check_count;
  logic [7:0]             rd;
  logic                   err;
  logic [7:0]             cfg_byte;
  logic                   cfg_load;

  csr_core_regs i_dut (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .pwdata_in   (pwdata_in),
    .pstrb_in    (pstrb_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .core_req_in (core_req_in),
    .cfg_byte_in (cfg_byte),
    .cfg_load_in (cfg_load),
    .view_out    (view_out)
  );

  // Clock of 25 ns period.
  always #12.5 core_clk_in = ~core_clk_in;

  // Compares one result and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the byte address is four times the register index.
  // The request stands until pready is seen high; one idle edge follows.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= {22'h0, idx, 2'b00};
    pwdata_in  <= {24'h0, d};
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge core_clk_in);
    end while (pready_out !== 1'b1);
    rd  = prdata_out[7:0];
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge core_clk_in);
  endtask

  // Reads a register and compares the byte returned.
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk({8'h0, rd}, {8'h0, exp});
  endtask

  // Presents one core operation for one edge, then lets the result settle.
  task automatic op(input csr_pkg::csr_op_t o, input logic [7:0] v);
    core_req_in <= '{op: o, operand: v};
    @(posedge core_clk_in);
    core_req_in <= '{op: csr_pkg::CSR_OP_NONE, operand: 8'h00};
    @(posedge core_clk_in);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog that cuts a hang short.
  initial begin
    #(25 * 20000);
    errors++;
    results();
  end

  // Main test sequence.
  initial begin
    core_clk_in = 1'b0;
    rst_in      = 1'b1;
    psel_in     = 1'b0;
    penable_in  = 1'b0;
    pwrite_in   = 1'b0;
    paddr_in    = '0;
    pwdata_in   = '0;
    pstrb_in    = 4'hF;
    core_req_in = '{op: csr_pkg::CSR_OP_NONE, operand: 8'h00};
    cfg_byte    = 8'h00;
    cfg_load    = 1'b0;
    errors      = 0;
    check_count = 0;
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    rchk(`CSR_OFF_SP, 8'h07);
    rchk(`CSR_OFF_DPL, 8'h00);
    rchk(`CSR_OFF_DPH, 8'h00);
    rchk(`CSR_OFF_PSW, 8'h00);
    rchk(`CSR_OFF_ACC, 8'h00);
    rchk(`CSR_OFF_B, 8'h00);
    rchk(8'h10, 8'h00);
    chk({15'h0, err}, 16'h1);
    // First push after reset lands at 08H.
    core_req_in <= '{op: csr_pkg::CSR_OP_PUSH, operand: 8'h3C};
    @(negedge core_clk_in);
    chk({8'h0, view_out.stack_wr_addr}, 16'h0008);
    chk({15'h0, view_out.stack_wr_en}, 16'h0001);
    @(posedge core_clk_in);
    core_req_in <= '{op: csr_pkg::CSR_OP_NONE, operand: 8'h00};
    @(posedge core_clk_in);
    chk({8'h0, view_out.sp}, 16'h0008);
    // Data pointer bytes join into one word.
    apb(1'b1, `CSR_OFF_DPL, 8'h5A);
    apb(1'b1, `CSR_OFF_DPH, 8'hA5);
    chk(view_out.wide_data_pointer, 16'hA55A);
    // Add and subtract flags: carry, nibble carry, overflow, parity.
    apb(1'b1, `CSR_OFF_ACC, 8'hFF);
    op(csr_pkg::CSR_OP_ADD, 8'h01);
    chk({8'h0, view_out.status_word}, 16'h00C0);
    apb(1'b1, `CSR_OFF_ACC, 8'h7F);
    op(csr_pkg::CSR_OP_ADD, 8'h01);
    chk({view_out.acc, view_out.status_word}, 16'h8045);
    apb(1'b1, `CSR_OFF_ACC, 8'h00);
    op(csr_pkg::CSR_OP_SUBB, 8'h01);
    chk({view_out.acc, view_out.status_word}, 16'hFFC0);
    // Product above 255 sets overflow and clears carry.
    apb(1'b1, `CSR_OFF_ACC, 8'h10);
    apb(1'b1, `CSR_OFF_B, 8'h10);
    apb(1'b1, `CSR_OFF_PSW, 8'h80);
    op(csr_pkg::CSR_OP_MUL, 8'h00);
    chk({view_out.acc, view_out.b}, 16'h0001);
    chk({8'h0, view_out.status_word}, 16'h0004);
    // Divide by zero sets overflow and clears carry.
    apb(1'b1, `CSR_OFF_ACC, 8'h33);
    apb(1'b1, `CSR_OFF_B, 8'h00);
    apb(1'b1, `CSR_OFF_PSW, 8'h80);
    op(csr_pkg::CSR_OP_DIV, 8'h00);
    chk({8'h0, view_out.status_word}, 16'h0004);
    // Compare sets carry only when the first operand is below.
    apb(1'b1, `CSR_OFF_ACC, 8'h05);
    op(csr_pkg::CSR_OP_COMPARE_BRANCH_INSTR, 8'h06);
    chk({15'h0, view_out.status_word[7]}, 16'h0001);
    op(csr_pkg::CSR_OP_COMPARE_BRANCH_INSTR, 8'h04);
    chk({15'h0, view_out.status_word[7]}, 16'h0000);
    // Decimal adjust past 99 sets carry.
    apb(1'b1, `CSR_OFF_ACC, 8'h9A);
    op(csr_pkg::CSR_OP_DA, 8'h00);
    chk({15'h0, view_out.status_word[7]}, 16'h0001);
    // User flags hold, parity stays live.
    apb(1'b1, `CSR_OFF_ACC, 8'h00);
    apb(1'b1, `CSR_OFF_PSW, 8'h23);
    rchk(`CSR_OFF_PSW, 8'h22);
    apb(1'b1, `CSR_OFF_ACC, 8'h01);
    rchk(`CSR_OFF_PSW, 8'h23);
    // Every bank select code maps to its base.
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `CSR_OFF_PSW, {3'b000, k[1:0], 3'b000});
      chk({11'h0, view_out.bank_base}, 16'(k * 8));
      chk({14'h0, view_out.bank}, 16'(k));
    end
    // Protected soft reset: refused without unlock, then taken.
    apb(1'b1, `CSR_OFF_RSTCTL, 8'h01);
    chk(view_out.wide_data_pointer, 16'hA55A);
    apb(1'b1, `CSR_OFF_TA, 8'hAA);
    apb(1'b1, `CSR_OFF_TA, 8'h55);
    apb(1'b1, `CSR_OFF_RSTCTL, 8'h01);
    repeat (2) @(posedge core_clk_in);
    rchk(`CSR_OFF_DPL, 8'h00);
    rchk(`CSR_OFF_DPH, 8'hA5);
    // Configuration byte load replaces the reset-control contents.
    cfg_byte <= 8'h02;
    cfg_load <= 1'b1;
    @(posedge core_clk_in);
    cfg_load <= 1'b0;
    @(posedge core_clk_in);
    rchk(`CSR_OFF_RSTCTL, 8'h02);
    results();
  end
endmodule // tb_top
`default_nettype wire
